// ==== verilog/ocr_regs.sv ====
// Output-2 and DAC channel 2 configuration register bank with decoded controls
//
// What this block does
// - First output-2 config register at index 0x6C, resets to 0x20.
// - Plus-leg drive bits 7-6, reset 0: line out, headphone, 4 ohm, receiver.
// - Plus-leg level bits 5-3, reset 4: codes 0-6 give 24 down to -12 dB.
// - Register one bit 2: minus bypass impedance, 0 is 4.4k, 1 is 20k.
// - Register one bit 1: bypass input, 0 differential, 1 single-ended.
// - Register one bit 0: channel 2 bandwidth, 0 audio, 1 wide.
// - Second output-2 config register at index 0x6D, resets to 0x20.
// - Minus-leg drive bits 7-6 use the same four drive encodings.
// - Minus-leg level bits 5-3, reset 4, same gains, code 7 reserved.
// - Register two bit 2: plus bypass impedance, 0 is 4.4k, 1 is 20k.
// - Register two bit 1: full scale, 0 is 2 Vrms, 1 is 4 Vrms.
// - Register two bit 0: common-mode tolerance, 0 limited, 1 rail to rail.
// - Sub-channel 2A volume register at index 0x6E, resets to 0xC9.
// - Volume code 0 mutes, 1 is -100 dB, 201 is 0 dB, 255 is +27 dB.
`timescale 1ns/1ps
module ocr_regs
  import ocr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output ocr_leg_t plus_leg_q,
  output ocr_leg_t minus_leg_q,
  output ocr_chan_t chan2_cfg_q,
  output ocr_vol_t sub_a_vol_q
);

  // ****************************************
  // Local signals
  // ****************************************
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_hit;
  logic [REG_W-1:0] cfg_one_q;
  logic [REG_W-1:0] cfg_two_q;
  logic [REG_W-1:0] vol_a_q;
  logic [REG_W-1:0] status_d;
  logic low_lane;

  // Only the low byte lane carries register data
  assign low_lane = wr_en && wr_strb[0];

  // ****************************************
  // Bus front end
  // ****************************************
  ocr_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ****************************************
  // Level code to gain in dB
  // ****************************************
  // Reserved code gives 0 dB and a cleared valid flag, so the analog
  // stage never sees an out-of-table gain
  function automatic logic signed [6:0] level_gain(input logic [2:0] code);
    logic signed [6:0] g;
    g = '0;
    if (code != LEVEL_RSVD_CODE) begin
      g = 7'(LEVEL_TOP_DB - LEVEL_STEP_DB * $signed({4'h0, code}));
    end
    return g;
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    case (wr_addr)
      CFG_ONE_ADDR, CFG_TWO_ADDR, VOL_A_ADDR, STATUS_ADDR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Stored registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_one_q <= CFG_ONE_RST;
    end else if (low_lane && wr_addr == CFG_ONE_ADDR) begin
      cfg_one_q <= wr_data[REG_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_two_q <= CFG_TWO_RST;
    end else if (low_lane && wr_addr == CFG_TWO_ADDR) begin
      cfg_two_q <= wr_data[REG_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vol_a_q <= VOL_A_RST;
    end else if (low_lane && wr_addr == VOL_A_ADDR) begin
      vol_a_q <= wr_data[REG_W-1:0];
    end
  end

  // ****************************************
  // Status: live view of decoded state, read only
  // ****************************************
  always_comb begin
    status_d = '0;
    status_d[ST_PLUS_LVL_RSVD] = cfg_one_q[LEVEL_MSB:LEVEL_LSB] == LEVEL_RSVD_CODE;
    status_d[ST_MINUS_LVL_RSVD] = cfg_two_q[LEVEL_MSB:LEVEL_LSB] == LEVEL_RSVD_CODE;
    // Higher full scale is only meant for audio bandwidth
    status_d[ST_FS_CONFLICT] = cfg_two_q[MID_BIT] && cfg_one_q[LOW_BIT];
    status_d[ST_MUTED] = vol_a_q == VOL_MUTE_CODE;
  end

  // ****************************************
  // Read mux, upper bits read as zero
  // ****************************************
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case (rd_addr)
      CFG_ONE_ADDR: rd_data[REG_W-1:0] = cfg_one_q;
      CFG_TWO_ADDR: rd_data[REG_W-1:0] = cfg_two_q;
      VOL_A_ADDR: rd_data[REG_W-1:0] = vol_a_q;
      STATUS_ADDR: rd_data[REG_W-1:0] = status_d;
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Plus leg controls
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      plus_leg_q.drive <= ocr_drive_t'(CFG_ONE_RST[DRIVE_MSB:DRIVE_LSB]);
      plus_leg_q.level <= CFG_ONE_RST[LEVEL_MSB:LEVEL_LSB];
      plus_leg_q.gain_db <= level_gain(CFG_ONE_RST[LEVEL_MSB:LEVEL_LSB]);
      plus_leg_q.level_ok <= 1'b1;
    end else begin
      plus_leg_q.drive <= ocr_drive_t'(cfg_one_q[DRIVE_MSB:DRIVE_LSB]);
      plus_leg_q.level <= cfg_one_q[LEVEL_MSB:LEVEL_LSB];
      plus_leg_q.gain_db <= level_gain(cfg_one_q[LEVEL_MSB:LEVEL_LSB]);
      // Flag code 7 so the analog side can ignore it
      plus_leg_q.level_ok <= !status_d[ST_PLUS_LVL_RSVD];
    end
  end

  // ****************************************
  // Minus leg controls
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      minus_leg_q.drive <= ocr_drive_t'(CFG_TWO_RST[DRIVE_MSB:DRIVE_LSB]);
      minus_leg_q.level <= CFG_TWO_RST[LEVEL_MSB:LEVEL_LSB];
      minus_leg_q.gain_db <= level_gain(CFG_TWO_RST[LEVEL_MSB:LEVEL_LSB]);
      minus_leg_q.level_ok <= 1'b1;
    end else begin
      minus_leg_q.drive <= ocr_drive_t'(cfg_two_q[DRIVE_MSB:DRIVE_LSB]);
      minus_leg_q.level <= cfg_two_q[LEVEL_MSB:LEVEL_LSB];
      minus_leg_q.gain_db <= level_gain(cfg_two_q[LEVEL_MSB:LEVEL_LSB]);
      minus_leg_q.level_ok <= !status_d[ST_MINUS_LVL_RSVD];
    end
  end

  // ****************************************
  // Channel 2 path controls
  // ****************************************
  // Passed through as written; the software-side limits are reported in
  // status instead of being overridden here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan2_cfg_q.minus_bypass_20k <= CFG_ONE_RST[IMP_BIT];
      chan2_cfg_q.bypass_single_ended <= CFG_ONE_RST[MID_BIT];
      chan2_cfg_q.wide_bandwidth <= CFG_ONE_RST[LOW_BIT];
      chan2_cfg_q.plus_bypass_20k <= CFG_TWO_RST[IMP_BIT];
      chan2_cfg_q.full_scale_4vrms <= CFG_TWO_RST[MID_BIT];
      chan2_cfg_q.cm_rail_to_rail <= CFG_TWO_RST[LOW_BIT];
    end else begin
      chan2_cfg_q.minus_bypass_20k <= cfg_one_q[IMP_BIT];
      chan2_cfg_q.bypass_single_ended <= cfg_one_q[MID_BIT];
      chan2_cfg_q.wide_bandwidth <= cfg_one_q[LOW_BIT];
      chan2_cfg_q.plus_bypass_20k <= cfg_two_q[IMP_BIT];
      chan2_cfg_q.full_scale_4vrms <= cfg_two_q[MID_BIT];
      chan2_cfg_q.cm_rail_to_rail <= cfg_two_q[LOW_BIT];
    end
  end

  // ****************************************
  // Sub-channel 2A digital volume
  // ****************************************
  // Gain in half-dB steps: code 1 gives -200, code 255 gives +54
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_a_vol_q.code <= VOL_A_RST;
      sub_a_vol_q.mute <= 1'b0;
      sub_a_vol_q.gain_half_db <= '0;
    end else begin
      sub_a_vol_q.code <= vol_a_q;
      sub_a_vol_q.mute <= vol_a_q == VOL_MUTE_CODE;
      sub_a_vol_q.gain_half_db <= $signed({1'b0, vol_a_q} - VOL_UNITY_CODE);
    end
  end

endmodule // ocr_regs

// ==== verilog/ocr_pkg.sv ====
// Package for the output-2 and DAC channel 2 configuration register bank
package ocr_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam int unsigned REG_W = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // Register indices; byte address is four times the index
  // ****************************************
  localparam logic [7:0] CFG_ONE_IDX = 8'h6C;
  localparam logic [7:0] CFG_TWO_IDX = 8'h6D;
  localparam logic [7:0] VOL_A_IDX = 8'h6E;
  localparam logic [7:0] STATUS_IDX = 8'h80;

  localparam logic [ADDR_W-1:0] CFG_ONE_ADDR = {2'h0, CFG_ONE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CFG_TWO_ADDR = {2'h0, CFG_TWO_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] VOL_A_ADDR = {2'h0, VOL_A_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [REG_W-1:0] CFG_ONE_RST = 8'h20;
  localparam logic [REG_W-1:0] CFG_TWO_RST = 8'h20;
  localparam logic [REG_W-1:0] VOL_A_RST = 8'hC9;

  // ****************************************
  // Field positions, shared by both configuration registers
  // ****************************************
  localparam int unsigned DRIVE_MSB = 7;
  localparam int unsigned DRIVE_LSB = 6;
  localparam int unsigned LEVEL_MSB = 5;
  localparam int unsigned LEVEL_LSB = 3;
  localparam int unsigned IMP_BIT = 2;
  localparam int unsigned MID_BIT = 1;
  localparam int unsigned LOW_BIT = 0;

  // Status register bits
  localparam int unsigned ST_PLUS_LVL_RSVD = 0;
  localparam int unsigned ST_MINUS_LVL_RSVD = 1;
  localparam int unsigned ST_FS_CONFLICT = 2;
  localparam int unsigned ST_MUTED = 3;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [2:0] LEVEL_RSVD_CODE = 3'h7;
  localparam logic signed [6:0] LEVEL_TOP_DB = 7'sd24;
  localparam logic signed [6:0] LEVEL_STEP_DB = 7'sd6;
  localparam logic [7:0] VOL_MUTE_CODE = 8'h00;
  localparam logic [8:0] VOL_UNITY_CODE = 9'h0C9;

  typedef enum logic [1:0] {
    OCR_DRIVE_LINE_OUT,
    OCR_DRIVE_HEADPHONE,
    OCR_DRIVE_FOUR_OHM,
    OCR_DRIVE_RECEIVER
  } ocr_drive_t;

  typedef struct packed {
    ocr_drive_t drive;
    logic [2:0] level;
    logic signed [6:0] gain_db;
    logic level_ok;
  } ocr_leg_t;

  typedef struct packed {
    logic minus_bypass_20k;
    logic plus_bypass_20k;
    logic bypass_single_ended;
    logic wide_bandwidth;
    logic full_scale_4vrms;
    logic cm_rail_to_rail;
  } ocr_chan_t;

  typedef struct packed {
    logic [7:0] code;
    logic mute;
    logic signed [8:0] gain_half_db;
  } ocr_vol_t;

endpackage

// ==== verilog/ocr_axil_slave.sv ====
// AXI4-Lite slave front end for the configuration register bank
`timescale 1ns/1ps
module ocr_axil_slave
  import ocr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [STRB_W-1:0] wr_strb,
  input wire logic wr_hit,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_hit
);

  logic aw_held_q;
  logic w_held_q;

  // Both halves held and no response pending: commit once
  assign wr_en = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  // ****************************************
  // Write address and data capture, in either order
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      s_axi_wready <= 1'b1;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // ****************************************
  // Write response
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Read channel: data sampled at the address handshake
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ocr_axil_slave

// ==== bench/ocr_regs_assertions.sv ====
// Port-level checker for the output-2 and channel 2 register bank
`timescale 1ns/1ps
module ocr_regs_checker
  import ocr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ocr_leg_t plus_leg_q,
  input wire ocr_leg_t minus_leg_q,
  input wire ocr_chan_t chan2_cfg_q,
  input wire ocr_vol_t sub_a_vol_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    return a == CFG_ONE_ADDR || a == CFG_TWO_ADDR || a == VOL_A_ADDR || a == STATUS_ADDR;
  endfunction

  // ****************************************
  // Bus sequencing
  // ****************************************
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  wr_resp_a: assert property (wr_taken |=> b_late)
    else $error("write response not two edges after take");
  wr_decerr_a: assert property (wr_taken and !hit(s_axi_awaddr) |=>
    b_late ##0 s_axi_bresp == RESP_DECERR)
    else $error("unmapped write not refused");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted during response");
  rd_ok_a: assert property (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr) |=>
    s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("mapped read answer wrong");
  rd_decerr_a: assert property (s_axi_arvalid && s_axi_arready && !hit(s_axi_araddr) |=>
    s_axi_rvalid && s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answer wrong");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data not held");

  // ****************************************
  // Stored fields and decode
  // ****************************************
  vol_commit_a: assert property (wr_taken and s_axi_awaddr == VOL_A_ADDR
    && s_axi_wstrb[0] |-> ##3 sub_a_vol_q.code == $past(s_axi_wdata[7:0], 3))
    else $error("volume code not taken from write");
  vol_decode_a: assert property (sub_a_vol_q.mute == (sub_a_vol_q.code == 8'h00)
    && sub_a_vol_q.gain_half_db == $signed({1'b0, sub_a_vol_q.code}) - 9'sd201)
    else $error("volume decode wrong");
  leg_decode_a: assert property (plus_leg_q.level_ok == (plus_leg_q.level != 3'h7)
    && (plus_leg_q.level_ok -> plus_leg_q.gain_db == 7'(24 - 6 * plus_leg_q.level)))
    else $error("plus leg gain decode wrong");
  minus_decode_a: assert property (minus_leg_q.level_ok == (minus_leg_q.level != 3'h7)
    && (minus_leg_q.level_ok -> minus_leg_q.gain_db == 7'(24 - 6 * minus_leg_q.level)))
    else $error("minus leg gain decode wrong");
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
    s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid
    && sub_a_vol_q.code == VOL_A_RST && plus_leg_q.level == 3'h4 && chan2_cfg_q == 6'h00)
    else $error("reset state wrong");
endmodule // ocr_regs_checker

bind ocr_regs ocr_regs_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .plus_leg_q, .minus_leg_q, .chan2_cfg_q,
  .sub_a_vol_q);

// ==== bench/test_output2_dac2_config_regs.sv ====
// Self-checking bench for the output-2 and channel 2 register bank
`timescale 1ns/1ps
module test_output2_dac2_config_regs;
  import ocr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [STRB_W-1:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  ocr_leg_t plus_leg_q;
  ocr_leg_t minus_leg_q;
  ocr_chan_t chan2_cfg_q;
  ocr_vol_t sub_a_vol_q;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [7:0] m1, m2, mv;
  logic [7:0] vt [9];
  logic [1:0] resp;
  logic [31:0] rd;

  ocr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .plus_leg_q, .minus_leg_q, .chan2_cfg_q, .sub_a_vol_q);

  always #2.5 aclk = ~aclk;

  task test_done;
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ****************************************
  // Bus master tasks, entered just after an edge
  // ****************************************
  task axw(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      // Ready stays high: lowering it here would clash with the next raise
      if (s_axi_bvalid && s_axi_bready) begin
        resp = s_axi_bresp;
        break;
      end
    end
  endtask

  task axr(input logic [ADDR_W-1:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        break;
      end
    end
  endtask

  // ****************************************
  // Reference model
  // ****************************************
  function automatic logic [12:0] leg(input logic [7:0] r);
    logic [6:0] g;
    g = (r[5:3] == 3'h7) ? 7'h00 : 7'(24 - 6 * int'(r[5:3]));
    return {r[7:3], g, r[5:3] != 3'h7};
  endfunction

  task wm(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    axw(a, d, 4'($urandom) | 4'h1);
    chk(34'(resp), 34'(RESP_OKAY));
    if (a == CFG_ONE_ADDR) m1 = d;
    if (a == CFG_TWO_ADDR) m2 = d;
    if (a == VOL_A_ADDR) mv = d;
  endtask

  task chk_state;
    logic [3:0] st;
    st = {mv == 8'h00, m2[1] & m1[0], m2[5:3] == 3'h7, m1[5:3] == 3'h7};
    repeat (2) @(posedge aclk);
    chk(34'(plus_leg_q), 34'(leg(m1)));
    chk(34'(minus_leg_q), 34'(leg(m2)));
    chk(34'(chan2_cfg_q),
      {28'h0, m1[2], m2[2], m1[1], m1[0], m2[1], m2[0]});
    chk(34'(sub_a_vol_q), {16'h0, mv, mv == 8'h00, 9'(int'(mv) - 201)});
    axr(CFG_ONE_ADDR);
    chk({resp, rd}, {RESP_OKAY, 24'h0, m1});
    axr(CFG_TWO_ADDR);
    chk({resp, rd}, {RESP_OKAY, 24'h0, m2});
    axr(VOL_A_ADDR);
    chk({resp, rd}, {RESP_OKAY, 24'h0, mv});
    axr(STATUS_ADDR);
    chk({resp, rd}, {RESP_OKAY, 28'h0, st});
  endtask

  initial begin
    void'($urandom(32'h3eab));
    vt = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hCA, 8'hFE, 8'hFF, 8'($urandom), 8'($urandom)};
    m1 = CFG_ONE_RST;
    m2 = CFG_TWO_RST;
    mv = VOL_A_RST;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_state();
    // Every drive, level and low-bit pattern on both legs
    for (int l = 0; l < 8; l++) begin
      wm(CFG_ONE_ADDR, {2'(l), 3'(l), 3'(l)});
      wm(CFG_TWO_ADDR, {2'(l + 1), 3'(7 - l), 3'(l + 3)});
      chk_state();
    end
    foreach (vt[i]) begin
      wm(VOL_A_ADDR, vt[i]);
      chk_state();
    end
    axw(12'h1BC, 8'h5A, 4'hF);
    chk(34'(resp), 34'(RESP_DECERR));
    axr(12'h1BC);
    chk({resp, rd}, {RESP_DECERR, 32'h0000_0000});
    axw(VOL_A_ADDR, 8'h5A, 4'hE);
    chk(34'(resp), 34'(RESP_OKAY));
    axw(STATUS_ADDR, 8'hFF, 4'hF);
    chk(34'(resp), 34'(RESP_OKAY));
    chk_state();
    // Second reset in mid-run restores every field
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    m1 = CFG_ONE_RST;
    m2 = CFG_TWO_RST;
    mv = VOL_A_RST;
    @(posedge aclk);
    chk_state();
    test_done();
  end
endmodule // test_output2_dac2_config_regs
